/* csfr_pkg.sv */
// Package of register offsets, field positions and reset values for the CPU status flag register bank
package csfr_pkg;
  // Byte offsets on the bus
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_INTCTL = 12'h004;
  localparam logic [11:0] OFS_IRQST = 12'h008;
  localparam logic [11:0] OFS_IRQMSK = 12'h00C;
  // Status word bit positions, plus the nesting-disable bit of the interrupt control register
  localparam int B_OVA = 15;
  localparam int B_OVB = 14;
  localparam int B_SATA = 13;
  localparam int B_SATB = 12;
  localparam int B_OVC = 11;
  localparam int B_SATC = 10;
  localparam int B_LOOP = 9;
  localparam int B_HC = 8;
  localparam int B_PRIO_LO = 5;
  localparam int B_NEST_DIS = 15;
  // Event bits in the interrupt status register
  localparam int E_OVA = 0;
  localparam int E_OVB = 1;
  localparam int E_SATA = 2;
  localparam int E_SATB = 3;
  localparam int NEV = 4;
  // Reset values
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [15:0] RST_INTCTL = 16'h0000;
  localparam logic [3:0] RST_EV = 4'h0;
  // AHB transfer type codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

/* csfr_halfcarry.sv */
`timescale 1ns/1ns
// Half-carry and borrow detector for byte and word ALU operations
module csfr_halfcarry (
  // Operands
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire logic carry_in,
  input wire logic is_sub,
  input wire logic is_byte,
  // Result
  output logic half_carry
);
  logic [4:0] nib_sum;
  logic [8:0] byte_sum;
  logic [3:0] nib_b;
  logic [7:0] byte_b;
  // Subtraction is add of inverted operand; carry out low means borrow in, so flag is carry out either way
  always_comb begin
    nib_b = is_sub ? ~op_b[3:0] : op_b[3:0];
    byte_b = is_sub ? ~op_b[7:0] : op_b[7:0];
    nib_sum = {1'b0, op_a[3:0]} + {1'b0, nib_b} + {4'h0, carry_in};
    byte_sum = {1'b0, op_a[7:0]} + {1'b0, byte_b} + {8'h00, carry_in};
    half_carry = is_byte ? nib_sum[4] : byte_sum[8];
  end
endmodule

/* csfr_event.sv */
`timescale 1ns/1ns
// Rising-edge detector on a same-clock flag, used to raise interrupt events
module csfr_event (
  // Clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Flag in and event out
  input wire logic flag,
  output logic rise
);
  logic prev_r;
  // Remember last value; frozen with clock enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else if (ce) begin
      prev_r <= flag;
    end
  end
  assign rise = flag & ~prev_r;
endmodule

/* csfr_top.sv */
`timescale 1ns/1ns
// CPU status flag register bank with AHB-Lite slave and event interrupt
module csfr_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Accumulator datapath status, same clock
  input wire logic acc_a_ovf,
  input wire logic acc_b_ovf,
  input wire logic acc_a_sat,
  input wire logic acc_b_sat,
  input wire logic hw_loop_active,
  // ALU half-carry source, same clock
  input wire logic alu_valid,
  input wire logic [15:0] alu_op_a,
  input wire logic [15:0] alu_op_b,
  input wire logic alu_carry_in,
  input wire logic alu_is_sub,
  input wire logic alu_is_byte,
  // Outputs
  output logic [15:0] cpu_status_word,
  output logic [2:0] cpu_priority_level,
  output logic irq
);
  typedef struct packed {
    logic ova;
    logic ovb;
    logic sata;
    logic satb;
    logic loop_act;
    logic hc;
    logic [2:0] prio;
    logic [4:0] low;
    logic [15:0] intctl;
    logic [3:0] ev;
    logic [3:0] msk;
    logic ph_act;
    logic ph_wr;
    logic [11:0] ph_addr;
    logic [31:0] rdata;
    logic irq;
  } csfr_state_t;

  csfr_state_t st_r;
  csfr_state_t st_nxt;
  logic hc_calc;
  logic [3:0] rise;
  logic [15:0] sw;
  logic [15:0] wd;

  // Decode of status-word read value, used for bus reads and the output port
  function automatic logic [15:0] csfr_pack(input csfr_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[csfr_pkg::B_OVA] = s.ova;
    v[csfr_pkg::B_OVB] = s.ovb;
    v[csfr_pkg::B_SATA] = s.sata;
    v[csfr_pkg::B_SATB] = s.satb;
    v[csfr_pkg::B_OVC] = s.ova | s.ovb;
    v[csfr_pkg::B_SATC] = s.sata | s.satb;
    v[csfr_pkg::B_LOOP] = s.loop_act;
    v[csfr_pkg::B_HC] = s.hc;
    v[csfr_pkg::B_PRIO_LO +: 3] = s.prio;
    v[4:0] = s.low;
    return v;
  endfunction

  csfr_halfcarry u_hc (
    .op_a(alu_op_a),
    .op_b(alu_op_b),
    .carry_in(alu_carry_in),
    .is_sub(alu_is_sub),
    .is_byte(alu_is_byte),
    .half_carry(hc_calc)
  );

  // Events: overflow and saturation onsets
  genvar gi;
  generate
    for (gi = 0; gi < csfr_pkg::NEV; gi++) begin : g_ev
      logic src;
      assign src = (gi == csfr_pkg::E_OVA) ? acc_a_ovf :
                   (gi == csfr_pkg::E_OVB) ? acc_b_ovf :
                   (gi == csfr_pkg::E_SATA) ? acc_a_sat : acc_b_sat;
      csfr_event u_ev (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .flag(src),
        .rise(rise[gi])
      );
    end
  endgenerate

  assign sw = csfr_pack(st_r);
  assign wd = hwdata[15:0];

  // Next state: bus phases, flag updates, event capture
  always_comb begin
    st_nxt = st_r;
    // Overflow flags follow the accumulators, loop flag follows the sequencer
    st_nxt.ova = acc_a_ovf;
    st_nxt.ovb = acc_b_ovf;
    st_nxt.loop_act = hw_loop_active;
    if (alu_valid) begin
      st_nxt.hc = hc_calc;
    end
    // Data phase of a write
    if (st_r.ph_act && st_r.ph_wr) begin
      unique case (st_r.ph_addr)
        csfr_pkg::OFS_STATUS: begin
          st_nxt.sata = wd[csfr_pkg::B_SATA];
          st_nxt.satb = wd[csfr_pkg::B_SATB];
          if (!wd[csfr_pkg::B_SATC]) begin
            st_nxt.sata = 1'b0;
            st_nxt.satb = 1'b0;
          end
          st_nxt.hc = wd[csfr_pkg::B_HC];
          st_nxt.low = wd[4:0];
          // Priority field locked while nesting is disabled
          if (!st_r.intctl[csfr_pkg::B_NEST_DIS]) begin
            st_nxt.prio = wd[csfr_pkg::B_PRIO_LO +: 3];
          end
        end
        csfr_pkg::OFS_INTCTL: st_nxt.intctl = wd;
        csfr_pkg::OFS_IRQMSK: st_nxt.msk = hwdata[3:0];
        default: ;
      endcase
    end
    // Read clears only the event bits it reported; an event that landed in the address phase is not lost
    if (st_r.ph_act && !st_r.ph_wr && st_r.ph_addr == csfr_pkg::OFS_IRQST) begin
      st_nxt.ev = st_r.ev & ~st_r.rdata[3:0];
    end
    // Saturation is sticky and the set wins over a same-cycle clear
    if (acc_a_sat) begin
      st_nxt.sata = 1'b1;
    end
    if (acc_b_sat) begin
      st_nxt.satb = 1'b1;
    end
    st_nxt.ev = st_nxt.ev | rise;
    // Address phase capture
    st_nxt.ph_act = hsel && hready && (htrans == csfr_pkg::HTRANS_NONSEQ || htrans == csfr_pkg::HTRANS_SEQ);
    st_nxt.ph_wr = hwrite;
    st_nxt.ph_addr = haddr[11:0];
    // Read data registered so hrdata stands during the data phase
    st_nxt.rdata = 32'h0000_0000;
    if (st_nxt.ph_act && !hwrite) begin
      unique case (haddr[11:0])
        csfr_pkg::OFS_STATUS: st_nxt.rdata = {16'h0000, sw};
        csfr_pkg::OFS_INTCTL: st_nxt.rdata = {16'h0000, st_r.intctl};
        csfr_pkg::OFS_IRQST: st_nxt.rdata = {28'h000_0000, st_r.ev};
        csfr_pkg::OFS_IRQMSK: st_nxt.rdata = {28'h000_0000, st_r.msk};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    st_nxt.irq = |(st_nxt.ev & st_nxt.msk);
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.intctl <= csfr_pkg::RST_INTCTL;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs taken from flip-flops; hreadyout and hresp are tied constants
  logic [15:0] sw_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sw_r <= csfr_pkg::RST_STATUS;
    end else if (ce) begin
      sw_r <= csfr_pack(st_nxt);
    end
  end

  assign cpu_status_word = sw_r;
  assign cpu_priority_level = st_r.prio;
  assign irq = st_r.irq;
  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0;
endmodule

/* csfr_assertions.sv */
// Port-level checks of the status flag register bank
`timescale 1ns/1ns
module csfr_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Datapath inputs
  input wire logic acc_a_ovf,
  input wire logic acc_b_ovf,
  input wire logic acc_a_sat,
  input wire logic acc_b_sat,
  input wire logic alu_valid,
  input wire logic [15:0] alu_op_a,
  input wire logic [15:0] alu_op_b,
  input wire logic alu_carry_in,
  input wire logic alu_is_sub,
  input wire logic alu_is_byte,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Status word
  input wire logic [15:0] cpu_status_word
);
  logic [8:0] lo_sum;
  logic hc_exp;
  // Carry into bit 4 is recovered from the sum, so one adder serves both sizes
  assign lo_sum = {1'b0, alu_op_a[7:0]} + {1'b0, alu_op_b[7:0]} + {8'h00, alu_carry_in};
  assign hc_exp = alu_is_byte ? (lo_sum[4] ^ alu_op_a[4] ^ alu_op_b[4]) : lo_sum[8];
  // One clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ovf_summary: assert property (cpu_status_word[11] == (cpu_status_word[15] | cpu_status_word[14]))
    else $error("combined overflow flag wrong");
  a_ovf_a_follow: assert property (ce |=> cpu_status_word[15] == $past(acc_a_ovf))
    else $error("overflow flag A wrong");
  a_ovf_b_follow: assert property (ce |=> cpu_status_word[14] == $past(acc_b_ovf))
    else $error("overflow flag B wrong");
  a_sat_a_set: assert property (ce && acc_a_sat |=> cpu_status_word[13])
    else $error("saturation flag A not set");
  a_sat_b_set: assert property (ce && acc_b_sat |=> cpu_status_word[12])
    else $error("saturation flag B not set");
  a_sat_summary: assert property (cpu_status_word[10] == (cpu_status_word[13] | cpu_status_word[12]))
    else $error("combined saturation flag wrong");
  a_half_carry: assert property (ce && alu_valid && !alu_is_sub |=> cpu_status_word[8] == $past(hc_exp))
    else $error("half carry flag wrong");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
endmodule
bind csfr_top csfr_chk u_chk (.clk, .reset_n, .ce, .acc_a_ovf, .acc_b_ovf, .acc_a_sat, .acc_b_sat, .alu_valid,
  .alu_op_a, .alu_op_b, .alu_carry_in, .alu_is_sub, .alu_is_byte, .hreadyout, .hresp, .cpu_status_word);

/* tb_cpu_status_flag_register.sv */
// Self-checking bench for the status flag register bank
`timescale 1ns/1ns
module tb_cpu_status_flag_register;
  logic clk = 1'b0, reset_n = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic acc_a_ovf = 1'b0, acc_b_ovf = 1'b0, acc_a_sat = 1'b0, acc_b_sat = 1'b0, hw_loop_active = 1'b0;
  logic alu_valid = 1'b0, alu_carry_in = 1'b0, alu_is_byte = 1'b0;
  logic [15:0] alu_op_a = 16'h0000, alu_op_b = 16'h0000, cpu_status_word;
  logic [2:0] cpu_priority_level;
  int fail_count = 0, total_checks = 0;
  // Clock
  always #5 clk = ~clk;
  // Design under test
  csfr_top dut (.clk, .reset_n, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .acc_a_ovf, .acc_b_ovf, .acc_a_sat, .acc_b_sat,
    .hw_loop_active, .alu_valid, .alu_op_a, .alu_op_b, .alu_carry_in, .alu_is_sub(1'b0), .alu_is_byte,
    .cpu_status_word, .cpu_priority_level, .irq);
  task chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One AHB single transfer; read data lands in q
  task bus(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= csfr_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task t_ovf;
    acc_a_ovf <= 1'b1;
    hw_loop_active <= 1'b1;
    tick(3);
    chk(cpu_status_word & 16'hCA00, 16'h8A00);
    acc_a_ovf <= 1'b0;
    acc_b_ovf <= 1'b1;
    tick(3);
    chk(cpu_status_word & 16'hC800, 16'h4800);
    acc_b_ovf <= 1'b0;
    tick(3);
    chk(cpu_status_word & 16'hC800, 16'h0000);
  endtask
  // Both overflow rises are pending; unmask, read-clear, then an unmapped slot
  task t_irq;
    chk({15'h0000, irq}, 16'h0000);
    bus(1'b1, csfr_pkg::OFS_IRQMSK, 16'h0001);
    tick(2);
    chk({15'h0000, irq}, 16'h0001);
    bus(1'b0, csfr_pkg::OFS_IRQST, 16'h0000);
    chk(q[15:0], 16'h0003);
    tick(2);
    chk({15'h0000, irq}, 16'h0000);
    bus(1'b1, 12'h010, 16'hFFFF);
    bus(1'b0, 12'h010, 16'h0000);
    chk(q[15:0], 16'h0000);
  endtask
  // Short pulses must leave sticky bits; both ways of clearing are used
  task t_sat;
    acc_a_sat <= 1'b1;
    tick(1);
    acc_a_sat <= 1'b0;
    tick(4);
    chk(cpu_status_word & 16'h3400, 16'h2400);
    bus(1'b1, csfr_pkg::OFS_STATUS, 16'h0400);
    tick(3);
    chk(cpu_status_word & 16'h3400, 16'h0000);
    acc_a_sat <= 1'b1;
    acc_b_sat <= 1'b1;
    tick(1);
    {acc_a_sat, acc_b_sat} <= 2'h0;
    tick(4);
    chk(cpu_status_word & 16'h3400, 16'h3400);
    bus(1'b1, csfr_pkg::OFS_STATUS, 16'h3000);
    tick(3);
    chk(cpu_status_word & 16'h3400, 16'h0000);
  endtask
  // Table of adds: flags are carry in, byte size, expected half carry
  task t_hc;
    static logic [15:0] av[5] = '{16'h000F, 16'h000E, 16'h000E, 16'h00FF, 16'h000F};
    static logic [2:0] fl[5] = '{3'h3, 3'h2, 3'h7, 3'h1, 3'h0};
    for (int i = 0; i < 5; i++) begin
      alu_op_a <= av[i];
      alu_op_b <= 16'h0001;
      {alu_carry_in, alu_is_byte} <= fl[i][2:1];
      alu_valid <= 1'b1;
      tick(1);
      alu_valid <= 1'b0;
      tick(3);
      chk(cpu_status_word & 16'h0100, {7'h00, fl[i][0], 8'h00});
    end
  endtask
  task t_ipl;
    bus(1'b1, csfr_pkg::OFS_STATUS, 16'h00A0);
    tick(2);
    chk({13'h0000, cpu_priority_level}, 16'h0005);
    bus(1'b1, csfr_pkg::OFS_INTCTL, 16'h8000);
    bus(1'b1, csfr_pkg::OFS_STATUS, 16'h0060);
    tick(2);
    chk({13'h0000, cpu_priority_level}, 16'h0005);
    bus(1'b1, csfr_pkg::OFS_INTCTL, 16'h0000);
    bus(1'b1, csfr_pkg::OFS_STATUS, 16'h0060);
    tick(2);
    chk({13'h0000, cpu_priority_level}, 16'h0003);
  endtask
  task give_verdict;
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(4);
    reset_n <= 1'b1;
    tick(1);
    t_ovf;
    t_irq;
    t_sat;
    t_hc;
    t_ipl;
    give_verdict;
  end
  // Watchdog far beyond the roughly 93 cycles needed
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
endmodule
